// ### battery_logger_status_led.sv
// Status LED sequencer and serial reading link of a battery light logger.
// Assumes sensor, threshold and log schedule come from logic on i_clk;
// the battery comparators and serial line are asynchronous pins.
`include "battery_logger_map.svh"
`timescale 1ns/1ps
`default_nettype none
module battery_logger_status_led #(
   parameter logic [35:0] BOOT_CYC = 36'(`BOOT_CYC),
   parameter logic [35:0] MEAS_NOM_CYC = 36'(`MEAS_NOM_CYC),
   parameter logic [35:0] MEAS_MAX_CYC = 36'(`MEAS_MAX_CYC),
   parameter logic [35:0] FADE_CYC = 36'(`FADE_CYC),
   parameter logic [35:0] MINUTE_CYC = 36'(`MINUTE_CYC),
   parameter logic [35:0] FLASH_ON_CYC = 36'(`FLASH_ON_CYC),
   parameter logic [35:0] FLASH_OFF_CYC = 36'(`FLASH_OFF_CYC),
   parameter int BAUD_DIV = int'(`BAUD_DIV)
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Battery comparators: bit0 >4.9V, 1 >4.8V, 2 >4.6V, 3 >4.4V, 4 >4.2V, 5 >4.0V
   input wire logic [5:0] i_batt_above,
   // Sensor front end
   input wire logic i_meas_valid,
   input wire battery_logger_pkg::reading_t i_reading,
   input wire logic [15:0] i_threshold,
   input wire logic i_log_due,
   // Serial line
   input wire logic i_rxd,
   output logic o_txd,
   // Phase outputs
   output logic o_led,
   output logic o_sensor_pwr,
   output logic o_fw_update_en,
   output logic o_meas_start,
   output logic o_meas_slow,
   // Record store
   output logic o_store,
   output logic [15:0] o_store_value
);
   initial begin
      if (BOOT_CYC == 36'h0 || FADE_CYC < 36'h100 || FLASH_ON_CYC == 36'h0)
         $error("timing parameters too small");
      if (MEAS_NOM_CYC > MEAS_MAX_CYC) $error("nominal time above maximum");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   battery_logger_pkg::phase_t phase;
   logic [35:0] tmr;
   logic [35:0] min_cnt;
   logic minute_tick;
   logic [5:0] batt_meta;
   logic [5:0] batt;
   logic [2:0] flashes;
   logic [2:0] flash_left;
   logic flash_on;
   logic [7:0] duty;
   logic [7:0] pwm;
   logic [35:0] fade_step;
   logic next_led;
   logic rx_valid;
   logic [7:0] rx_data;
   logic [7:0] prev1;
   logic [7:0] prev2;
   logic cmd_hit;
   logic sending;
   logic [319:0] line;
   logic [5:0] chars_left;
   logic tx_valid;
   logic tx_ready;

   // Battery level to flash count; lowest level shows six
   function automatic logic [2:0] flash_count(input logic [5:0] above);
      logic [2:0] n;
      n = `FLASH_MAX;
      for (int i = 5; i >= 0; i--) begin
         if (above[i]) n = 3'(i + 1);
      end
      return n;
   endfunction

   // Binary value to ASCII hex digits, most significant first
   function automatic logic [63:0] hex8(input logic [31:0] v);
      logic [63:0] s;
      logic [3:0] d;
      s = 64'h0;
      for (int i = 0; i < 8; i++) begin
         d = v[i*4 +: 4];
         s[i*8 +: 8] = (d < 4'ha) ? (8'h30 + 8'(d)) : (8'h57 + 8'(d));
      end
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   // Comparators move slowly, but the sample point must still be clean
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         batt_meta <= 6'h00;
         batt <= 6'h00;
      end else begin
         batt_meta <= i_batt_above;
         batt <= batt_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Minute clock

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         min_cnt <= 36'h0;
         minute_tick <= 1'b0;
      end else begin
         minute_tick <= (min_cnt == MINUTE_CYC - 36'h1);
         min_cnt <= (min_cnt == MINUTE_CYC - 36'h1) ? 36'h0 : min_cnt + 36'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Phase sequencer

   // Boot, measure, flash, sleep, wake; one timer shared by all phases but sleep, which waits for the minute tick
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         phase <= battery_logger_pkg::ST_BOOT;
         tmr <= 36'h0;
         flashes <= 3'h1;
         flash_left <= 3'h0;
         flash_on <= 1'b0;
         o_store <= 1'b0;
         o_store_value <= 16'h0000;
         o_meas_start <= 1'b0;
         o_meas_slow <= 1'b0;
      end else begin
         o_store <= 1'b0;
         o_meas_start <= 1'b0;
         tmr <= tmr + 36'h1;
         case (phase)
            battery_logger_pkg::ST_BOOT: begin
               // steady LED for the boot period
               if (tmr == BOOT_CYC - 36'h1) begin
                  phase <= battery_logger_pkg::ST_MEAS;
                  tmr <= 36'h0;
                  o_meas_start <= 1'b1;
                  o_meas_slow <= 1'b0;
               end
            end
            battery_logger_pkg::ST_MEAS: begin
               // flag slow readings, abandon at the maximum
               if (tmr == MEAS_NOM_CYC) o_meas_slow <= 1'b1;
               if (i_meas_valid || tmr == MEAS_MAX_CYC - 36'h1) begin
                  // record only if due and above threshold
                  if (i_meas_valid && i_log_due && i_reading.magnitude > i_threshold) begin
                     o_store <= 1'b1;
                     o_store_value <= i_reading.magnitude;
                  end
                  flashes <= flash_count(batt);
                  flash_left <= flash_count(batt);
                  flash_on <= 1'b1;
                  phase <= battery_logger_pkg::ST_FLASH;
                  tmr <= 36'h0;
               end
            end
            battery_logger_pkg::ST_FLASH: begin
               // short flashes, count set by battery level
               if (flash_on && tmr == FLASH_ON_CYC - 36'h1) begin
                  flash_on <= 1'b0;
                  tmr <= 36'h0;
               end else if (!flash_on && tmr == FLASH_OFF_CYC - 36'h1) begin
                  tmr <= 36'h0;
                  if (flash_left == 3'h1) begin
                     phase <= battery_logger_pkg::ST_SLEEP;
                  end else begin
                     flash_left <= flash_left - 3'h1;
                     flash_on <= 1'b1;
                  end
               end
            end
            battery_logger_pkg::ST_SLEEP: begin
               if (minute_tick) begin
                  phase <= battery_logger_pkg::ST_WAKE;
                  tmr <= 36'h0;
               end
            end
            battery_logger_pkg::ST_WAKE: begin
               if (tmr == FADE_CYC - 36'h1) begin
                  tmr <= 36'h0;
                  if (i_log_due) begin
                     phase <= battery_logger_pkg::ST_MEAS;
                     o_meas_start <= 1'b1;
                     o_meas_slow <= 1'b0;
                  end else begin
                     // no record due, still repeat the flashes
                     flashes <= flash_count(batt);
                     flash_left <= flash_count(batt);
                     flash_on <= 1'b1;
                     phase <= battery_logger_pkg::ST_FLASH;
                  end
               end
            end
            default: begin
               phase <= battery_logger_pkg::ST_BOOT;
               tmr <= 36'h0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // LED drive

   // fade from full to off; 256 duty steps across the fade time
   assign fade_step = FADE_CYC >> 8;

   // Duty decrements on a step boundary and is full on entering wake
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         duty <= 8'hff;
         pwm <= 8'h00;
      end else begin
         pwm <= pwm + 8'h01;
         if (phase != battery_logger_pkg::ST_WAKE) begin
            duty <= 8'hff;
         end else if (tmr != 36'h0 && (tmr % fade_step) == 36'h0 && duty != 8'h00) begin
            duty <= duty - 8'h01;
         end
      end
   end

   // LED source per phase, registered for a clean pin
   always_comb begin
      next_led = 1'b0;
      case (phase)
         battery_logger_pkg::ST_BOOT: next_led = 1'b1;
         battery_logger_pkg::ST_FLASH: next_led = flash_on;
         battery_logger_pkg::ST_WAKE: next_led = (duty == 8'hff) || (pwm < duty); // Full is solid
         default: next_led = 1'b0;
      endcase
   end

   // sensor power in every phase but sleep, update window during boot
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_led <= 1'b0;
         o_sensor_pwr <= 1'b0;
         o_fw_update_en <= 1'b0;
      end else begin
         o_led <= next_led;
         o_sensor_pwr <= (phase != battery_logger_pkg::ST_SLEEP);
         o_fw_update_en <= (phase == battery_logger_pkg::ST_BOOT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial command link

   logger_uart_rx #(.DIV(BAUD_DIV)) u_rx (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_rxd(i_rxd),
      .o_valid(rx_valid),
      .o_data(rx_data)
   );

   logger_uart_tx #(.DIV(BAUD_DIV)) u_tx (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_valid(tx_valid),
      .i_data(line[319:312]),
      .o_ready(tx_ready),
      .o_txd(o_txd)
   );

   // reading request is the two letters then carriage return
   assign cmd_hit = rx_valid && rx_data == `CH_CR && prev2 == `CH_R && prev1 == `CH_X;

   // Last two characters of the command stream
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prev1 <= 8'h00;
         prev2 <= 8'h00;
      end else if (rx_valid) begin
         prev2 <= (rx_data == `CH_CR) ? 8'h00 : prev1;
         prev1 <= (rx_data == `CH_CR) ? 8'h00 : rx_data;
      end
   end

   // reply line latched whole, so fields stay consistent while sent
   // a request arriving mid-reply is dropped
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         sending <= 1'b0;
         line <= 320'h0;
         chars_left <= 6'h00;
         tx_valid <= 1'b0;
      end else begin
         tx_valid <= 1'b0;
         if (!sending && cmd_hit) begin
            // magnitude, frequency, count, period, temperature in hex
            line <= {`CH_R, `CH_COMMA, 32'(hex8({16'h0, i_reading.magnitude})),
                     `CH_COMMA, hex8(i_reading.frequency), `CH_COMMA,
                     hex8(i_reading.count), `CH_COMMA, hex8(i_reading.period),
                     `CH_COMMA, 32'(hex8({16'h0, i_reading.temperature})),
                     `CH_CR, `CH_LF};
            chars_left <= `REPLY_CHARS;
            sending <= 1'b1;
         end else if (sending && tx_valid) begin
            line <= {line[311:0], 8'h00};
            chars_left <= chars_left - 6'h01;
            sending <= (chars_left != 6'h01);
         end else if (sending && tx_ready) begin
            tx_valid <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   sequence boot_phase_s;
      phase == battery_logger_pkg::ST_BOOT;
   endsequence
   sequence meas_end_s;
      phase == battery_logger_pkg::ST_MEAS ##1 phase == battery_logger_pkg::ST_FLASH;
   endsequence

   boot_led_on_a: assert property (@(posedge i_clk) disable iff (i_rst)
      boot_phase_s ##1 boot_phase_s |-> o_led && o_fw_update_en)
      else $error("LED or update window off during boot");
   store_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
      o_store |-> $past(i_log_due && i_meas_valid && i_reading.magnitude > i_threshold))
      else $error("record stored without cause");
   meas_bound_a: assert property (@(posedge i_clk) disable iff (i_rst)
      phase == battery_logger_pkg::ST_MEAS |-> tmr < MEAS_MAX_CYC)
      else $error("measurement ran past its maximum");
   flash_code_a: assert property (@(posedge i_clk) disable iff (i_rst)
      meas_end_s |-> flashes == flash_count($past(batt)) && flashes != 3'h0)
      else $error("flash count does not match battery");
   batt_sample_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(flashes) |-> $past(phase) inside {battery_logger_pkg::ST_MEAS,
                                                battery_logger_pkg::ST_WAKE})
      else $error("battery sampled outside measurement end");
   minute_wake_a: assert property (@(posedge i_clk) disable iff (i_rst)
      phase == battery_logger_pkg::ST_SLEEP && minute_tick |=>
      phase == battery_logger_pkg::ST_WAKE ##1 o_led)
      else $error("minute wake missed");
   fade_full_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $rose(phase == battery_logger_pkg::ST_WAKE) |-> duty == 8'hff ##1 duty == 8'hff)
      else $error("fade did not start at full");
   reply_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
      cmd_hit && !sending |=> sending && chars_left == `REPLY_CHARS ##[1:3] tx_valid)
      else $error("reading request not answered");
endmodule
`default_nettype wire

// ### battery_logger_map.svh
// Constant map for the battery logger status sequencer.
// Assumes a single 40 MHz clock; all times given in ms, cycle counts derived here.
`ifndef BATTERY_LOGGER_MAP_SVH
`define BATTERY_LOGGER_MAP_SVH

// Clock and link rate
`define CLK_HZ 64'd40000000
`define BAUD_RATE 64'd115200
`define BAUD_DIV (`CLK_HZ / `BAUD_RATE)

// Phase times in milliseconds
`define BOOT_MS 64'd3000
`define MEAS_NOM_MS 64'd8000
`define MEAS_MAX_MS 64'd300000
`define FADE_MS 64'd1000
`define MINUTE_MS 64'd60000
`define FLASH_ON_MS 64'd100
`define FLASH_OFF_MS 64'd200

// Derived cycle counts: least times round up, longest round down
`define MS_UP(ms) (((ms) * `CLK_HZ + 64'd999) / 64'd1000)
`define MS_DN(ms) (((ms) * `CLK_HZ) / 64'd1000)
`define BOOT_CYC `MS_UP(`BOOT_MS)
`define MEAS_NOM_CYC `MS_UP(`MEAS_NOM_MS)
`define MEAS_MAX_CYC `MS_DN(`MEAS_MAX_MS)
`define FADE_CYC `MS_DN(`FADE_MS)
`define MINUTE_CYC `MS_DN(`MINUTE_MS)
`define FLASH_ON_CYC `MS_UP(`FLASH_ON_MS)
`define FLASH_OFF_CYC `MS_UP(`FLASH_OFF_MS)

// Battery flash counts
`define FLASH_MAX 3'h6

// Command characters and reply layout
`define CH_R 8'h72
`define CH_X 8'h78
`define CH_COMMA 8'h2c
`define CH_CR 8'h0d
`define CH_LF 8'h0a
`define REPLY_CHARS 6'h28

`endif

// ### battery_logger_pkg.sv
// Types shared by the battery logger sequencer and its top bench.
// Assumes the constant map is included where numbers are needed.
package battery_logger_pkg;

   // Sequencer phases, one-hot
   typedef enum logic [4:0] {
      ST_BOOT  = 5'b00001,
      ST_MEAS  = 5'b00010,
      ST_FLASH = 5'b00100,
      ST_SLEEP = 5'b01000,
      ST_WAKE  = 5'b10000
   } phase_t;

   // One light reading as delivered by the sensor front end
   typedef struct packed {
      logic [15:0] magnitude;
      logic [31:0] frequency;
      logic [31:0] count;
      logic [31:0] period;
      logic [15:0] temperature;
   } reading_t;

endpackage

// ### logger_uart_rx.sv
// Serial receiver, 8 data bits, no parity, one stop bit.
// Assumes the line input is asynchronous; it is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module logger_uart_rx #(
   parameter int DIV = 347
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Serial line
   input wire logic i_rxd,
   // Received byte
   output logic o_valid,
   output logic [7:0] o_data
);
   initial begin
      if (DIV < 4) $error("DIV too small");
   end

   logic rx_meta;
   logic rx;
   logic busy;
   logic [15:0] cnt;
   logic [3:0] bit_no;
   logic [8:0] shift;

   // Two-flop synchroniser
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_meta <= 1'b1;
         rx <= 1'b1;
      end else begin
         rx_meta <= i_rxd;
         rx <= rx_meta;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         busy <= 1'b0;
         cnt <= 16'h0000;
         bit_no <= 4'h0;
         shift <= 9'h000;
         o_valid <= 1'b0;
         o_data <= 8'h00;
      end else begin
         o_valid <= 1'b0;
         if (!busy) begin
            if (!rx) begin
               busy <= 1'b1;
               cnt <= 16'(DIV / 2);
               bit_no <= 4'h0;
            end
         end else if (cnt != 16'h0000) begin
            cnt <= cnt - 16'h0001;
         end else begin
            cnt <= 16'(DIV - 1);
            if (bit_no == 4'h0 && rx) begin
               busy <= 1'b0; // Glitch, not a start bit
            end else if (bit_no == 4'h9) begin
               busy <= 1'b0;
               o_valid <= rx; // Bad stop bit drops the byte
               o_data <= shift[8:1];
            end else begin
               shift <= {rx, shift[8:1]};
               bit_no <= bit_no + 4'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### logger_uart_tx.sv
// Serial transmitter, 8 data bits, no parity, one stop bit, LSB first.
// Assumes the requester holds i_valid for one cycle while o_ready is high.
`timescale 1ns/1ps
`default_nettype none
module logger_uart_tx #(
   parameter int DIV = 347
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Byte to send
   input wire logic i_valid,
   input wire logic [7:0] i_data,
   output logic o_ready,
   // Serial line
   output logic o_txd
);
   initial begin
      if (DIV < 4) $error("DIV too small");
   end

   logic [15:0] cnt;
   logic [3:0] left;
   logic [9:0] shift;

   // bit timing from the baud divider
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt <= 16'h0000;
         left <= 4'h0;
         shift <= 10'h3ff;
         o_txd <= 1'b1;
         o_ready <= 1'b1;
      end else if (o_ready) begin
         if (i_valid) begin
            // start, eight data bits, one stop
            shift <= {1'b1, i_data, 1'b0};
            left <= 4'ha;
            cnt <= 16'h0000;
            o_ready <= 1'b0;
         end
      end else if (cnt != 16'h0000) begin
         cnt <= cnt - 16'h0001;
      end else if (left == 4'h0) begin
         o_ready <= 1'b1;
      end else begin
         o_txd <= shift[0];
         shift <= {1'b1, shift[9:1]};
         left <= left - 4'h1;
         cnt <= 16'(DIV - 1);
      end
   end

   txd_tick_a: assert property (@(posedge i_clk) disable iff (i_rst)
      $changed(o_txd) |-> $past(cnt) == 16'h0000)
      else $error("serial line moved off a bit boundary");
   start_bit_a: assert property (@(posedge i_clk) disable iff (i_rst)
      (o_ready && i_valid) |=> ##1 !o_txd)
      else $error("start bit not sent after accept");
endmodule
`default_nettype wire

// ### host_serial_model.sv
// Host end of the serial link: sends command bytes, collects reply bytes.
// Assumes 8N1 framing at DIV clocks per bit with the line idle high.
`timescale 1ns/1ps
`default_nettype none
module host_serial_model #(
   parameter int DIV = 8
) (
   // Clock
   input wire logic i_clk,
   // Serial lines
   input wire logic i_txd,
   output logic o_rxd
);
   logic [7:0] rx_q[$];
   int bad_stop = 0;
   initial o_rxd = 1'b1;
   ////////////////////////////////////////////////////////////
   // framed send
   // Start bit, eight bits LSB first, then stop leaves the line idle
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge i_clk) o_rxd <= f[i];
         repeat (DIV - 1) @(posedge i_clk);
      end
   endtask
   ////////////////////////////////////////////////////////////
   // framed receive
   // Sampled mid-bit; a low stop bit is counted, not stored
   initial begin
      logic [7:0] b;
      forever begin
         @(negedge i_txd);
         repeat (DIV / 2) @(posedge i_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (DIV) @(posedge i_clk);
            b[i] = i_txd;
         end
         repeat (DIV) @(posedge i_clk);
         if (i_txd !== 1'b1) bad_stop++;
         else rx_q.push_back(b);
      end
   end
endmodule
`default_nettype wire

// ### tb_top.sv
// Top bench of the status LED sequencer and its serial reading link.
// Assumes shortened phase counts; a host model sits on the serial pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int BOOT = 400;
   localparam int NOM = 500;
   localparam int MAXC = 2000;
   localparam int FADE = 512;
   localparam int DIV = 8;
   // Design inputs, all valued at time zero
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic [5:0] i_batt_above = 6'h3f;
   logic i_meas_valid = 1'b0;
   battery_logger_pkg::reading_t i_reading = '0;
   logic [15:0] i_threshold = 16'h0000;
   logic i_log_due = 1'b1;
   logic rxd, o_txd, o_led, o_sensor_pwr, o_fw_update_en, o_meas_start, o_meas_slow;
   logic o_store;
   logic [15:0] o_store_value, thr;
   logic [5:0] b_old;
   logic [7:0] cmd[4] = '{8'h78, 8'h72, 8'h78, 8'h0d};
   battery_logger_pkg::reading_t rd;
   int err_total = 0;
   int checked = 0;
   int seed = 32'h40506341;
   int store_cnt = 0;
   int cyc, hi, n;
   always #12.5 i_clk = ~i_clk;
   always @(posedge i_clk) if (o_store === 1'b1) store_cnt <= store_cnt + 1;
   battery_logger_status_led #(
      .BOOT_CYC(36'(BOOT)), .MEAS_NOM_CYC(36'(NOM)), .MEAS_MAX_CYC(36'(MAXC)),
      .FADE_CYC(36'(FADE)), .MINUTE_CYC(36'h1388), .FLASH_ON_CYC(36'h14),
      .FLASH_OFF_CYC(36'h28), .BAUD_DIV(DIV)
   ) battery_logger_status_led_i (
      .i_clk, .i_rst, .i_batt_above, .i_meas_valid, .i_reading, .i_threshold, .i_log_due,
      .i_rxd(rxd), .o_txd, .o_led, .o_sensor_pwr, .o_fw_update_en, .o_meas_start,
      .o_meas_slow, .o_store, .o_store_value
   );
   host_serial_model #(.DIV(DIV)) host_serial_model_i (.i_clk, .i_txd(o_txd), .o_rxd(rxd));
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Settled sample after each edge; lit cycles are tallied in hi
   task automatic tick;
      @(posedge i_clk);
      #1;
      hi += (o_led === 1'b1);
   endtask
   // Bounded wait: 0 start pulse, 1 sensor power up, 2 sensor power down
   task automatic wait_for(input int sel, input int lim);
      cyc = 0;
      do begin
         tick();
         cyc++;
         if (cyc > lim) begin
            chk(1, 0);
            report_and_stop();
         end
      end while (!(sel == 0 ? o_meas_start === 1'b1 : o_sensor_pwr === sel[0]));
   endtask
   function automatic int flashes(input logic [5:0] b);
      for (int i = 0; i < 6; i++) if (b[i]) return i + 1;
      return 6;
   endfunction
   // Reply character i: fixed punctuation, else hex nibbles MSB first
   function automatic logic [7:0] rep_char(input battery_logger_pkg::reading_t r, input int i);
      int j;
      logic [3:0] v;
      j = i - 2 - (i > 6) - (i > 15) - (i > 24) - (i > 33);
      v = 4'(r >> (124 - 4 * j));
      if (i == 0) return 8'h72;
      if (i == 1 || i == 6 || i == 15 || i == 24 || i == 33) return 8'h2c;
      if (i == 38) return 8'h0d;
      if (i == 39) return 8'h0a;
      return (v < 4'ha) ? 8'h30 + 8'(v) : 8'h57 + 8'(v);
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (3) tick();
      chk(o_fw_update_en, 1);
      hi = 0;
      wait_for(0, 1000);
      chk(hi > BOOT - 5 && hi < BOOT + 3, 1);
      tick();
      chk(o_fw_update_en, 0);
      // store just above threshold, battery moves after sampling
      thr = 16'($random(seed)) & 16'h7fff;
      rd = 128'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
      rd.magnitude = thr + 16'h0001;
      repeat (30) @(posedge i_clk);
      i_threshold <= thr;
      i_reading <= rd;
      @(posedge i_clk) i_meas_valid <= 1'b1;
      @(posedge i_clk) i_meas_valid <= 1'b0;
      hi = 0;
      repeat (3) tick();
      chk(store_cnt, 1);
      chk(o_store_value, rd.magnitude);
      @(posedge i_clk) i_batt_above <= 6'h00;
      wait_for(2, 2000);
      chk((hi + 10) / 20, 1);
      // request after a stray byte; one reply only
      foreach (cmd[k]) host_serial_model_i.send_byte(cmd[k]);
      n = 0;
      while (host_serial_model_i.rx_q.size() < 40 && n < 4000) begin
         tick();
         n++;
      end
      repeat (200) tick();
      chk(host_serial_model_i.rx_q.size(), 40);
      chk(host_serial_model_i.bad_stop, 0);
      for (int i = 0; i < host_serial_model_i.rx_q.size() && i < 40; i++) begin
         chk(host_serial_model_i.rx_q[i], rep_char(rd, i));
      end
      // minute wakes: no log, equal magnitude, no reading at all
      for (int k = 0; k < 3; k++) begin
         b_old = (k == 0) ? 6'h00 : 6'($random(seed));
         @(posedge i_clk);
         i_log_due <= (k != 0);
         i_batt_above <= b_old;
         i_threshold <= rd.magnitude;
         wait_for(2, 6000);
         wait_for(1, 6000);
         chk(o_led, 1);
         hi = 0;
         repeat (FADE - 8) tick();
         chk(hi > 64 && hi < FADE - 64, 1);
         n = store_cnt;
         if (k != 0) begin
            wait_for(0, 40);
            if (k == 1) begin
               repeat (20) @(posedge i_clk);
               i_meas_valid <= 1'b1;
               @(posedge i_clk) i_meas_valid <= 1'b0;
            end else begin
               repeat (NOM + 10) tick();
               chk(o_meas_slow, 1);
            end
         end
         hi = 0;
         wait_for(2, 3000);
         if (k == 2) chk(cyc > MAXC - NOM - 20, 1);
         chk(store_cnt, n);
         chk((hi + 10) / 20, flashes(b_old));
      end
      report_and_stop();
   end
endmodule
`default_nettype wire
